// *** design/csr_cfg.svh ***
// Purpose: constants for the core status and control register bank
// Assumes: 32-bit APB data, registers in the low 16 bits
// Notes: offsets are byte addresses
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH
`define CSR_OFF_STATUS 12'h000
`define CSR_OFF_CONTROL 12'h004
`define CSR_OFF_PAGE 12'h008
`define CSR_OFF_EVENT 12'h00C
`define CSR_ADDR_W 12
// status word fields
`define CSR_SR_OA 15
`define CSR_SR_OB 14
`define CSR_SR_SA 13
`define CSR_SR_SB 12
`define CSR_SR_OAB 11
`define CSR_SR_SAB 10
`define CSR_SR_DA 9
`define CSR_SR_DC 8
`define CSR_SR_IPL_HI 7
`define CSR_SR_IPL_LO 5
`define CSR_SR_RA 4
`define CSR_SR_N 3
`define CSR_SR_OV 2
`define CSR_SR_Z 1
`define CSR_SR_C 0
// control word fields
`define CSR_CC_US 12
`define CSR_CC_EDT 11
`define CSR_CC_DL_HI 10
`define CSR_CC_DL_LO 8
`define CSR_CC_ACC_A_CLIP_ENABLE 7
`define CSR_CC_ACC_B_CLIP_ENABLE 6
`define CSR_CC_STORE_CLIP_ENABLE 5
`define CSR_CC_CLIP_WIDTH_SELECT 4
`define CSR_CC_CPU_PRIORITY_TOP_BIT 3
`define CSR_CC_PSV 2
`define CSR_CC_RND 1
`define CSR_CC_IF 0
// reset values
`define CSR_SR_RESET 16'h0000
`define CSR_CC_RESET 16'h0020
`define CSR_PAGE_RESET 8'h00
// guard bits of a 40-bit accumulator
`define CSR_GUARD_HI 39
`define CSR_GUARD_LO 32
`define CSR_IPL_MAX 3'h7
`endif

// *** design/csr_pkg.sv ***
// Purpose: shared types for the core status and control bank
// Assumes: nothing
// Notes: constants live in csr_cfg.svh
`default_nettype none
package csr_pkg;
  typedef enum logic [1:0] {
    CSR_APB_IDLE,
    CSR_APB_SETUP,
    CSR_APB_ACCESS
  } csr_apb_st_t;
  typedef logic [15:0] csr_word_t;
endpackage
`default_nettype wire

// *** design/csr_alu_flags.sv ***
// Purpose: derive arithmetic condition flags from an operation's result
// Assumes: result, operands and carries come from the same-clock ALU
// Notes: purely combinational
`include "csr_cfg.svh"
`default_nettype none
module csr_alu_flags (
  input wire logic [15:0] alu_opa,
  input wire logic [15:0] alu_opb,
  input wire logic alu_sub,
  input wire logic alu_byte,
  output logic [16:0] alu_sum,
  output logic half_carry_flag,
  output logic flag_n,
  output logic flag_ov,
  output logic flag_nz,
  output logic flag_c
);
  import csr_pkg::*;
  logic [15:0] opb_eff;
  logic [4:0] nib_sum;
  logic [8:0] byte_sum;
  logic [8:0] low_sum;
  logic cin;
  logic s_a;
  logic s_b;
  logic s_r;
  always_comb begin
    cin = alu_sub;
    opb_eff = alu_sub ? ~alu_opb : alu_opb;
    alu_sum = {1'b0, alu_opa} + {1'b0, opb_eff} + {16'h0000, cin};
    nib_sum = {1'b0, alu_opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
    low_sum = {1'b0, alu_opa[7:0]} + {1'b0, opb_eff[7:0]} + {8'h00, cin};
    byte_sum = low_sum;
    // byte ops take the nibble carry, word ops the carry out of bit 7
    half_carry_flag = alu_byte ? nib_sum[4] : low_sum[8]; // R9 R10
    s_a = alu_byte ? alu_opa[7] : alu_opa[15];
    s_b = alu_byte ? opb_eff[7] : opb_eff[15];
    s_r = alu_byte ? byte_sum[7] : alu_sum[15];
    flag_n = s_r; // R11
    flag_ov = (s_a == s_b) && (s_r != s_a); // R12
    flag_nz = alu_byte ? (byte_sum[7:0] != 8'h00) : (alu_sum[15:0] != 16'h0000);
    // subtract leaves carry as inverted borrow through the complement form
    flag_c = alu_byte ? byte_sum[8] : alu_sum[16]; // R14
  end
endmodule // csr_alu_flags

// *** design/csr_guard_chk.sv ***
// Purpose: guard-bit overflow test for one 40-bit accumulator
// Assumes: accumulator value is from the core clock domain
// Notes: combinational
`include "csr_cfg.svh"
`default_nettype none
module csr_guard_chk (
  input wire logic [39:0] acc_val,
  output logic guard_ovf
);
  import csr_pkg::*;
  // guard bits 32..39 must agree, else the value ran into the guard bits
  assign guard_ovf = !((&acc_val[`CSR_GUARD_HI:`CSR_GUARD_LO]) ||
                       !(|acc_val[`CSR_GUARD_HI:`CSR_GUARD_LO])); // R4
endmodule // csr_guard_chk

// *** design/csr_core_regs.sv ***
// Functional notes
// (R1) per-accumulator clip sticky is set by hardware only; software may only clear it
// (R2) combined clip flag clears by software and clears both per-accumulator flags
// (R3) combined overflow equals OR of the two guard overflow flags
// (R4) guard overflow set while accumulator guard bits are not all identical
// (R5) priority is top bit over three low bits; level 7 or top bit masks
// (R6) low priority bits are read-only while nesting disable is set
// (R7) loop-block-active bit reads one while a block loop runs
// (R8) repeat-active bit reads one while a single-instruction repeat runs
// (R9) half carry from bit 7 for words, nibble boundary for bytes
// (R10) byte half carry taken between result bits 3 and 4
// (R11) negative flag follows the sign of the result
// (R12) overflow flag set on signed magnitude overflow, else cleared
// (R13) zero flag cleared by nonzero result, otherwise kept
// (R14) carry set on carry out of the msb; inverted borrow on subtract
// (R15) control bit selects unsigned multiplies when one
// (R16) early-exit write of one ends loop after this iteration; reads zero
// (R17) read-only nest-depth field reports active block loops, 0 to 7
// (R18) three enables turn on clipping for acc a, acc b and stores
// (R19) width select chooses 9.31 clipping when one, 1.31 when zero
// (R20) code window enable makes program memory visible in data space
// (R21) upper data half maps to program memory at the page register
// (R22) round select: one biased, zero convergent
// (R23) multiplier mode: one integer, zero fractional
//
// Purpose: status word, control word and window page over APB
// Assumes: core events arrive on pclk; pready is always high
// Notes: core flag updates win over software writes in the same cycle
`include "csr_cfg.svh"
`default_nettype none
module csr_core_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alu_valid,
  input wire logic [15:0] alu_opa,
  input wire logic [15:0] alu_opb,
  input wire logic alu_sub,
  input wire logic alu_byte,
  output logic [15:0] alu_result,
  input wire logic [39:0] acc_a,
  input wire logic [39:0] acc_b,
  input wire logic acc_a_clip_hit,
  input wire logic acc_b_clip_hit,
  input wire logic loop_start,
  input wire logic loop_end,
  input wire logic repeat_active_in,
  input wire logic nesting_disable,
  input wire logic ipl_write,
  input wire logic [3:0] ipl_wdata,
  input wire logic [15:0] data_addr,
  output logic [15:0] core_status_word,
  output logic [15:0] core_control_word,
  output logic [3:0] cpu_priority,
  output logic user_irq_masked,
  output logic loop_early_exit,
  output logic dsp_mul_unsigned,
  output logic acc_a_clip_enable,
  output logic acc_b_clip_enable,
  output logic store_clip_enable,
  output logic clip_width_select,
  output logic round_select,
  output logic mul_integer,
  output logic code_window_hit,
  output logic [22:0] code_window_addr
);
  import csr_pkg::*;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [11:0] addr_lo;
  logic wr_en;
  logic sel_sr;
  logic sel_cc;
  logic sel_pg;
  logic sel_ok;
  logic lo_lane;
  assign addr_lo = paddr[`CSR_ADDR_W-1:0];
  assign sel_sr = (addr_lo == `CSR_OFF_STATUS);
  assign sel_cc = (addr_lo == `CSR_OFF_CONTROL);
  assign sel_pg = (addr_lo == `CSR_OFF_PAGE);
  assign sel_ok = sel_sr | sel_cc | sel_pg;
  assign pready = 1'b1;
  // unmapped addresses answer with an error and change nothing
  assign pslverr = psel & penable & ~sel_ok;
  assign wr_en = psel & penable & pwrite & sel_ok;
  assign lo_lane = pstrb[0];

  // ----------------------------------------------------------------
  // arithmetic flags
  // ----------------------------------------------------------------
  logic [16:0] alu_sum;
  logic f_dc;
  logic f_n;
  logic f_ov;
  logic f_nz;
  logic f_c;
  csr_alu_flags u_flags (
    .alu_opa(alu_opa),
    .alu_opb(alu_opb),
    .alu_sub(alu_sub),
    .alu_byte(alu_byte),
    .alu_sum(alu_sum),
    .half_carry_flag(f_dc),
    .flag_n(f_n),
    .flag_ov(f_ov),
    .flag_nz(f_nz),
    .flag_c(f_c)
  );

  logic [4:0] alu_flags_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_flags_ff <= 5'h00;
      alu_result <= 16'h0000;
    end else if (alu_valid) begin
      alu_flags_ff[4] <= f_dc; // R9
      alu_flags_ff[3] <= f_n; // R11
      alu_flags_ff[2] <= f_ov; // R12
      alu_flags_ff[1] <= alu_flags_ff[1] & ~f_nz; // R13
      alu_flags_ff[0] <= f_c; // R14
      alu_result <= alu_sum[15:0];
    end else if (wr_en && sel_sr && lo_lane) begin
      alu_flags_ff[4] <= pwdata[`CSR_SR_DC];
      alu_flags_ff[3:0] <= pwdata[`CSR_SR_N:`CSR_SR_C];
    end
  end

  // ----------------------------------------------------------------
  // accumulator overflow and clip flags
  // ----------------------------------------------------------------
  logic acc_a_guard_overflow;
  logic acc_b_guard_overflow;
  logic either_acc_guard_overflow;
  csr_guard_chk u_guard_a (
    .acc_val(acc_a),
    .guard_ovf(acc_a_guard_overflow)
  );
  csr_guard_chk u_guard_b (
    .acc_val(acc_b),
    .guard_ovf(acc_b_guard_overflow)
  );
  assign either_acc_guard_overflow = acc_a_guard_overflow | acc_b_guard_overflow; // R3

  logic acc_a_clip_sticky_ff;
  logic acc_b_clip_sticky_ff;
  logic clr_a;
  logic clr_b;
  logic clr_ab;
  logic hi_lane;
  assign hi_lane = pstrb[1];
  // zero clears, one is ignored; clearing the combined bit clears both
  assign clr_ab = wr_en & sel_sr & hi_lane & ~pwdata[`CSR_SR_SAB]; // R2
  assign clr_a = (wr_en & sel_sr & hi_lane & ~pwdata[`CSR_SR_SA]) | clr_ab; // R1
  assign clr_b = (wr_en & sel_sr & hi_lane & ~pwdata[`CSR_SR_SB]) | clr_ab; // R1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_a_clip_sticky_ff <= 1'b0;
      acc_b_clip_sticky_ff <= 1'b0;
    end else begin
      // hardware set wins over a same-cycle clear
      acc_a_clip_sticky_ff <= acc_a_clip_hit | (acc_a_clip_sticky_ff & ~clr_a); // R1
      acc_b_clip_sticky_ff <= acc_b_clip_hit | (acc_b_clip_sticky_ff & ~clr_b); // R1
    end
  end

  // ----------------------------------------------------------------
  // loop tracking
  // ----------------------------------------------------------------
  logic [2:0] loop_nest_depth_ff;
  logic single_repeat_active_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_nest_depth_ff <= 3'h0;
    end else if (loop_start && !loop_end && loop_nest_depth_ff != `CSR_IPL_MAX) begin
      loop_nest_depth_ff <= loop_nest_depth_ff + 3'h1; // R17
    end else if (loop_end && !loop_start && loop_nest_depth_ff != 3'h0) begin
      loop_nest_depth_ff <= loop_nest_depth_ff - 3'h1; // R17
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_repeat_active_ff <= 1'b0;
    end else begin
      single_repeat_active_ff <= repeat_active_in; // R8
    end
  end
  logic loop_block_active;
  assign loop_block_active = (loop_nest_depth_ff != 3'h0); // R7

  // early exit is a one-cycle request; the bit itself never stores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_early_exit <= 1'b0;
    end else begin
      loop_early_exit <= wr_en & sel_cc & hi_lane & pwdata[`CSR_CC_EDT]
                         & loop_block_active; // R16
    end
  end

  // ----------------------------------------------------------------
  // priority level
  // ----------------------------------------------------------------
  logic [2:0] cpu_priority_low_bits_ff;
  logic cpu_priority_top_bit_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_priority_low_bits_ff <= 3'h0;
      cpu_priority_top_bit_ff <= 1'b0;
    end else if (ipl_write) begin
      // a load from the interrupt controller wins over a same-cycle software write
      cpu_priority_low_bits_ff <= ipl_wdata[2:0];
      cpu_priority_top_bit_ff <= ipl_wdata[3];
    end else begin
      if (wr_en && sel_sr && lo_lane && !nesting_disable) begin
        cpu_priority_low_bits_ff <= pwdata[`CSR_SR_IPL_HI:`CSR_SR_IPL_LO]; // R6
      end
      if (wr_en && sel_cc && lo_lane) begin
        cpu_priority_top_bit_ff <= pwdata[`CSR_CC_CPU_PRIORITY_TOP_BIT];
      end
    end
  end
  assign cpu_priority = {cpu_priority_top_bit_ff, cpu_priority_low_bits_ff}; // R5
  assign user_irq_masked = cpu_priority_top_bit_ff |
                           (cpu_priority_low_bits_ff == `CSR_IPL_MAX); // R5

  // ----------------------------------------------------------------
  // control word and window page
  // ----------------------------------------------------------------
  // bit 3 is a spare slot held at zero so the fields keep their word order
  localparam logic [15:0] cc_rst_val = `CSR_CC_RESET;
  logic [8:0] ctl_ff;
  logic [7:0] code_window_page_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= {cc_rst_val[`CSR_CC_US], cc_rst_val[`CSR_CC_ACC_A_CLIP_ENABLE:`CSR_CC_CLIP_WIDTH_SELECT], 1'b0,
                 cc_rst_val[`CSR_CC_PSV:`CSR_CC_IF]};
    end else if (wr_en && sel_cc) begin
      if (hi_lane) begin
        ctl_ff[8] <= pwdata[`CSR_CC_US]; // R15
      end
      if (lo_lane) begin
        ctl_ff[7:4] <= pwdata[`CSR_CC_ACC_A_CLIP_ENABLE:`CSR_CC_CLIP_WIDTH_SELECT]; // R18 R19
        ctl_ff[3:0] <= {1'b0, pwdata[`CSR_CC_PSV:`CSR_CC_IF]}; // R20 R22 R23
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_window_page_ff <= `CSR_PAGE_RESET;
    end else if (wr_en && sel_pg && lo_lane) begin
      code_window_page_ff <= pwdata[7:0]; // R21
    end
  end
  assign dsp_mul_unsigned = ctl_ff[8]; // R15
  assign acc_a_clip_enable = ctl_ff[7]; // R18
  assign acc_b_clip_enable = ctl_ff[6]; // R18
  assign store_clip_enable = ctl_ff[5]; // R18
  assign clip_width_select = ctl_ff[4]; // R19
  assign round_select = ctl_ff[1]; // R22
  assign mul_integer = ctl_ff[0]; // R23
  // upper data half becomes a 32k-word window into program memory
  assign code_window_hit = ctl_ff[2] & data_addr[15]; // R20 R21
  assign code_window_addr = {code_window_page_ff, data_addr[14:0]}; // R21

  // ----------------------------------------------------------------
  // read view
  // ----------------------------------------------------------------
  assign core_status_word = {acc_a_guard_overflow, acc_b_guard_overflow,
    acc_a_clip_sticky_ff, acc_b_clip_sticky_ff, either_acc_guard_overflow,
    acc_a_clip_sticky_ff | acc_b_clip_sticky_ff, loop_block_active, alu_flags_ff[4],
    cpu_priority_low_bits_ff, single_repeat_active_ff, alu_flags_ff[3:0]};
  assign core_control_word = {3'h0, ctl_ff[8], 1'b0, loop_nest_depth_ff, ctl_ff[7:4],
    cpu_priority_top_bit_ff, ctl_ff[2:0]};
  always_comb begin
    prdata = 32'h0000_0000;
    if (sel_sr) begin
      prdata = {16'h0000, core_status_word};
    end else if (sel_cc) begin
      prdata = {16'h0000, core_control_word};
    end else if (sel_pg) begin
      prdata = {24'h00_0000, code_window_page_ff};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SAB_OR: assert property (acc_a_clip_hit || acc_b_clip_hit // R2
    |=> core_status_word[`CSR_SR_SAB]) else $error("combined clip not set");
  AST_CLIP_SET: assert property (acc_a_clip_hit |=> acc_a_clip_sticky_ff) // R1
    else $error("clip hit lost");
  AST_CLIP_B_SET: assert property (acc_b_clip_hit |=> acc_b_clip_sticky_ff) // R1
    else $error("clip b hit lost");
  AST_CLIP_NOSET: assert property (!acc_a_clip_sticky_ff && !acc_a_clip_hit // R1
    |=> !acc_a_clip_sticky_ff) else $error("clip set by software");
  AST_SAB_CLR: assert property (clr_ab && !acc_b_clip_hit |=> !acc_b_clip_sticky_ff) // R2
    else $error("combined clear missed b");
  AST_OAB: assert property (core_status_word[`CSR_SR_OAB] == // R3
    (acc_a_guard_overflow | acc_b_guard_overflow)) else $error("oab wrong");
  AST_OA: assert property (core_status_word[`CSR_SR_OA] == // R4
    ((acc_a[`CSR_GUARD_HI:`CSR_GUARD_LO] != 8'h00) &&
    (acc_a[`CSR_GUARD_HI:`CSR_GUARD_LO] != 8'hFF))) else $error("guard overflow wrong");
  AST_IPL_RO: assert property (nesting_disable && !ipl_write // R6
    |=> $stable(cpu_priority_low_bits_ff)) else $error("priority written");
  AST_IPL_RW: assert property (wr_en && sel_sr && lo_lane && !nesting_disable // R6
    && !ipl_write |=> cpu_priority_low_bits_ff ==
    $past(pwdata[`CSR_SR_IPL_HI:`CSR_SR_IPL_LO])) else $error("priority write lost");
  AST_MASK: assert property (cpu_priority_top_bit_ff |-> user_irq_masked) // R5
    else $error("mask missing");
  AST_DA: assert property (loop_start && !loop_end |=> core_status_word[`CSR_SR_DA]) // R7
    else $error("loop active missing");
  AST_DEPTH_SAT: assert property (loop_nest_depth_ff == `CSR_IPL_MAX && loop_start // R17
    && !loop_end |=> loop_nest_depth_ff == `CSR_IPL_MAX) else $error("nest depth wrapped");
  AST_RA: assert property (repeat_active_in |=> core_status_word[`CSR_SR_RA]) // R8
    else $error("repeat bit late");
  AST_RA_LOW: assert property (!repeat_active_in |=> !core_status_word[`CSR_SR_RA]) // R8
    else $error("repeat bit stuck");
  AST_ZERO: assert property (alu_valid && f_nz |=> !core_status_word[`CSR_SR_Z]) // R13
    else $error("zero not cleared");
  AST_Z_KEEP: assert property (alu_valid && !f_nz // R13
    |=> $stable(core_status_word[`CSR_SR_Z])) else $error("zero flag not kept");
  AST_EDT_RD: assert property (core_control_word[`CSR_CC_EDT] == 1'b0) // R16
    else $error("early exit reads one");
  AST_EDT_PULSE: assert property (loop_early_exit |=> !loop_early_exit) // R16
    else $error("early exit held");
  AST_EDT_IDLE: assert property (!loop_block_active |=> !loop_early_exit) // R16
    else $error("early exit without loop");
  AST_US_KEEP: assert property (!(wr_en && sel_cc) |=> $stable(dsp_mul_unsigned)) // R15
    else $error("multiply mode changed");
endmodule // csr_core_regs
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for the core status and control bank
// Assumes: apb slave answers with pready; flags latch on the edge after alu_valid
// Notes: each scenario is one task; expectations are worked out by hand
`include "csr_cfg.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csr_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr;
  logic alu_valid = 1'b0, alu_sub = 1'b0, alu_byte = 1'b0;
  logic [15:0] alu_opa = 16'h0, alu_opb = 16'h0, alu_result, data_addr = 16'h0;
  logic [39:0] acc_a = 40'h0, acc_b = 40'h0;
  logic acc_a_clip_hit = 1'b0, acc_b_clip_hit = 1'b0, loop_start = 1'b0, loop_end = 1'b0;
  logic repeat_active_in = 1'b0, nesting_disable = 1'b0, ipl_write = 1'b0;
  logic [3:0] ipl_wdata = 4'h0, cpu_priority;
  csr_word_t core_status_word, core_control_word;
  logic user_irq_masked, loop_early_exit, dsp_mul_unsigned, acc_a_clip_enable;
  logic acc_b_clip_enable, store_clip_enable, clip_width_select, round_select, mul_integer;
  logic code_window_hit;
  logic [22:0] code_window_addr;
  logic [31:0] rd;
  logic er;
  int n_fail = 0;
  int checks_done = 0;
  always #4 pclk = ~pclk;
  csr_core_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alu_valid(alu_valid), .alu_opa(alu_opa),
    .alu_opb(alu_opb), .alu_sub(alu_sub), .alu_byte(alu_byte), .alu_result(alu_result),
    .acc_a(acc_a), .acc_b(acc_b), .acc_a_clip_hit(acc_a_clip_hit),
    .acc_b_clip_hit(acc_b_clip_hit), .loop_start(loop_start), .loop_end(loop_end),
    .repeat_active_in(repeat_active_in), .nesting_disable(nesting_disable),
    .ipl_write(ipl_write), .ipl_wdata(ipl_wdata), .data_addr(data_addr),
    .core_status_word(core_status_word), .core_control_word(core_control_word),
    .cpu_priority(cpu_priority), .user_irq_masked(user_irq_masked),
    .loop_early_exit(loop_early_exit), .dsp_mul_unsigned(dsp_mul_unsigned),
    .acc_a_clip_enable(acc_a_clip_enable), .acc_b_clip_enable(acc_b_clip_enable),
    .store_clip_enable(store_clip_enable), .clip_width_select(clip_width_select),
    .round_select(round_select), .mul_integer(mul_integer),
    .code_window_hit(code_window_hit), .code_window_addr(code_window_addr));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // master holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic alu(input logic [15:0] a, b, input logic s, y, input logic [15:0] m, e);
    @(posedge pclk);
    alu_opa <= a;
    alu_opb <= b;
    alu_sub <= s;
    alu_byte <= y;
    alu_valid <= 1'b1;
    @(posedge pclk);
    alu_valid <= 1'b0;
    #1;
    chk("alu flags", {16'h0, e & m}, {16'h0, core_status_word & m});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, `CSR_OFF_STATUS, 32'h0);
    chk("status reset", 32'h0, rd);
    apb(1'b0, `CSR_OFF_CONTROL, 32'h0);
    chk("control reset", 32'h0020, rd);
    chk("mapped err", 32'h0, {31'h0, er});
    apb(1'b0, `CSR_OFF_PAGE, 32'h0);
    chk("page reset", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask
  task automatic t_clip;
    apb(1'b1, `CSR_OFF_STATUS, 32'h3400);
    settle(1);
    chk("clip set by write", 32'h0, {16'h0, core_status_word & 16'h3400});
    @(posedge pclk);
    acc_a_clip_hit <= 1'b1;
    @(posedge pclk);
    acc_a_clip_hit <= 1'b0;
    settle(1);
    chk("clip a hit", 32'h2400, {16'h0, core_status_word & 16'h3400});
    apb(1'b1, `CSR_OFF_STATUS, 32'h2000);
    settle(1);
    chk("combined clear", 32'h0, {16'h0, core_status_word & 16'h3400});
    @(posedge pclk);
    acc_b_clip_hit <= 1'b1;
    @(posedge pclk);
    acc_b_clip_hit <= 1'b0;
    apb(1'b1, `CSR_OFF_STATUS, 32'h0400);
    settle(1);
    chk("clip b clear", 32'h0, {16'h0, core_status_word & 16'h1000});
    $display("test clip done");
  endtask
  task automatic t_guard;
    @(posedge pclk);
    acc_a <= 40'h01_0000_0000;
    settle(2);
    chk("guard a", 32'h8800, {16'h0, core_status_word & 16'hC800});
    @(posedge pclk);
    acc_a <= 40'hFF_FFFF_FFFF;
    acc_b <= 40'hFE_FFFF_FFFF;
    settle(2);
    chk("guard b", 32'h4800, {16'h0, core_status_word & 16'hC800});
    @(posedge pclk);
    acc_a <= 40'h00_8000_0000;
    acc_b <= 40'h0;
    settle(2);
    chk("guard none", 32'h0, {16'h0, core_status_word & 16'hC800});
    $display("test guard done");
  endtask
  task automatic t_alu;
    apb(1'b1, `CSR_OFF_STATUS, 32'h0002);
    alu(16'hFFFF, 16'h0001, 1'b0, 1'b0, 16'h010F, 16'h0103);
    alu(16'h7FFF, 16'h0001, 1'b0, 1'b0, 16'h010F, 16'h010C);
    alu(16'h0000, 16'h0000, 1'b0, 1'b0, 16'h010F, 16'h0000);
    alu(16'h0005, 16'h0003, 1'b1, 1'b0, 16'h010F, 16'h0101);
    alu(16'h0003, 16'h0005, 1'b1, 1'b0, 16'h010F, 16'h0008);
    alu(16'h8000, 16'h0001, 1'b1, 1'b0, 16'h010F, 16'h0005);
    alu(16'h000F, 16'h0001, 1'b0, 1'b1, 16'h0100, 16'h0100);
    alu(16'h000F, 16'h0001, 1'b0, 1'b0, 16'h0100, 16'h0000);
    $display("test alu done");
  endtask
  task automatic t_prio;
    apb(1'b1, `CSR_OFF_STATUS, 32'h00A0);
    settle(1);
    chk("prio 5", 32'h5, {27'h0, user_irq_masked, cpu_priority});
    apb(1'b1, `CSR_OFF_CONTROL, 32'h0028);
    settle(1);
    chk("prio 13", 32'h1D, {27'h0, user_irq_masked, cpu_priority});
    apb(1'b1, `CSR_OFF_CONTROL, 32'h0020);
    apb(1'b1, `CSR_OFF_STATUS, 32'h00E0);
    settle(1);
    chk("prio 7", 32'h17, {27'h0, user_irq_masked, cpu_priority});
    @(posedge pclk);
    nesting_disable <= 1'b1;
    apb(1'b1, `CSR_OFF_STATUS, 32'h0040);
    settle(1);
    chk("prio locked", 32'h7, {28'h0, cpu_priority});
    @(posedge pclk);
    ipl_write <= 1'b1;
    ipl_wdata <= 4'h2;
    @(posedge pclk);
    ipl_write <= 1'b0;
    nesting_disable <= 1'b0;
    settle(1);
    chk("prio core load", 32'h2, {28'h0, cpu_priority});
    $display("test priority done");
  endtask
  task automatic t_loops;
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge pclk);
      loop_start <= 1'b1;
      @(posedge pclk);
      loop_start <= 1'b0;
    end
    repeat_active_in <= 1'b1;
    settle(2);
    chk("depth max", 32'h7, {29'h0, core_control_word[10:8]});
    chk("loop active", 32'h1, {31'h0, core_status_word[9]});
    chk("repeat active", 32'h1, {31'h0, core_status_word[4]});
    apb(1'b1, `CSR_OFF_CONTROL, 32'h0820);
    #1;
    repeat (4) begin
      if (loop_early_exit === 1'b1) seen = 1'b1;
      @(posedge pclk);
      #1;
    end
    chk("early exit pulse", 32'h1, {31'h0, seen});
    apb(1'b0, `CSR_OFF_CONTROL, 32'h0);
    chk("early exit reads", 32'h0, {31'h0, rd[11]});
    repeat_active_in <= 1'b0;
    repeat (8) begin
      @(posedge pclk);
      loop_end <= 1'b1;
      @(posedge pclk);
      loop_end <= 1'b0;
    end
    settle(2);
    chk("depth zero", 32'h0, {29'h0, core_control_word[10:8]});
    chk("loop idle", 32'h0, {30'h0, core_status_word[9], core_status_word[4]});
    $display("test loops done");
  endtask
  task automatic t_ctrl;
    logic [15:0] v;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 16'h10F3 : 16'h0000;
      apb(1'b1, `CSR_OFF_CONTROL, {16'h0, v});
      apb(1'b0, `CSR_OFF_CONTROL, 32'h0);
      chk("control back", {16'h0, v}, rd);
      chk("control outs", (i == 0) ? 32'h7F : 32'h0, {25'h0, dsp_mul_unsigned,
        acc_a_clip_enable, acc_b_clip_enable, store_clip_enable, clip_width_select,
        round_select, mul_integer});
    end
    $display("test control done");
  endtask
  task automatic t_window;
    apb(1'b1, `CSR_OFF_PAGE, 32'h00A5);
    apb(1'b1, `CSR_OFF_CONTROL, 32'h0024);
    data_addr <= 16'h8123;
    settle(1);
    chk("window hit", 32'h1, {31'h0, code_window_hit});
    chk("window addr", {9'h0, 8'hA5, 15'h0123}, {9'h0, code_window_addr});
    @(posedge pclk);
    data_addr <= 16'h7FFF;
    settle(1);
    chk("lower half", 32'h0, {31'h0, code_window_hit});
    apb(1'b1, `CSR_OFF_CONTROL, 32'h0020);
    data_addr <= 16'h8123;
    settle(1);
    chk("window off", 32'h0, {31'h0, code_window_hit});
    $display("test window done");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_clip();
    t_guard();
    t_alu();
    t_prio();
    t_loops();
    t_ctrl();
    t_window();
    end_sim();
  end
endmodule // tb
`default_nettype wire
